/* verilog/p2c_port.sv */
// 16-line port with capture/compare alternate functions and fast irqs
// assumes pins and peripheral inputs synchronous to pclk; APB slave
// Contract
// - direction bit: 0 input, 1 drive; reset 0
// - open-drain bit: 0 push-pull, 1 open-drain
// - each line is capture/compare channel, same order
// - capture sees pin if input, latch if output
// - software latch write can cause capture
// - mode 1/double: match toggles the latch
// - mode 3: match sets, overflow clears latch
// - hardware latch update only on compare trigger
// - software may write latch during compare use
// - CPU write beats simultaneous compare trigger
// - lines 0-7 irq via capture, every 8 cycles
// - lines 8-15 capture 8 cycles, fast every cycle
// - lines 8-15 are fast irqs 0-7
// - line 15 feeds second unit timer count
// - fast irq edge: rising, falling or both
// - 2-bit source selector per fast irq
// - fast irq 3 alternate is clock alarm
// - selector codes: pin, alt, OR, AND
// - fast irq 2 alternate is seconds request
`include "p2c_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module p2c_port #(
  parameter int LINES = 16,
  parameter int FAST = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`P2C_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINES-1:0] pin_in,
  output logic [LINES-1:0] pin_out,
  output logic [LINES-1:0] pin_oe_n,
  input wire p2c_pkg::p2c_cmp_t cmp_req,
  output logic [LINES-1:0] capture_data,
  output logic capture_sample,
  input wire logic alt_rx0,
  input wire logic alt_rx1,
  input wire logic clock_seconds_request,
  input wire logic clock_alarm_request,
  output logic [FAST-1:0] fast_irq,
  output logic second_unit_timer_count_in
);

  logic [15:0] port_output_latch_r;
  logic [15:0] port_output_latch_nxt;
  logic [15:0] line_direction_r;
  logic [15:0] open_drain_control_r;
  logic [15:0] irq_source_select_r;
  logic [15:0] irq_edge_r;
  logic [15:0] pin_latch_r;
  logic [2:0] div_r;
  logic samp_en;
  logic [FAST-1:0] fast_src;
  logic [FAST-1:0] fast_prev_r;
  logic [FAST-1:0] alt_src;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [31:0] rd_mux;
  logic [15:0] wmask;
  logic [15:0] wdata16;
  logic [15:0] cap_view;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready & ~pslverr;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata16 = pwdata[15:0];

  // read decode; unmapped addresses answer with an error
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `P2C_ADDR_LATCH: rd_mux = {16'h0000, port_output_latch_r};
      `P2C_ADDR_DIR: rd_mux = {16'h0000, line_direction_r};
      `P2C_ADDR_ODC: rd_mux = {16'h0000, open_drain_control_r};
      `P2C_ADDR_SEL: rd_mux = {16'h0000, irq_source_select_r};
      `P2C_ADDR_EDGE: rd_mux = {16'h0000, irq_edge_r};
      default: hit = 1'b0;
    endcase
  end

  // answer is prepared in setup, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_direction_r <= `P2C_RST_DIR;
    end else if (wr_acc && paddr == `P2C_ADDR_DIR) begin
      line_direction_r <= (line_direction_r & ~wmask) | (wdata16 & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_drain_control_r <= `P2C_RST_ODC;
    end else if (wr_acc && paddr == `P2C_ADDR_ODC) begin
      open_drain_control_r <= (open_drain_control_r & ~wmask) |
                              (wdata16 & wmask);
    end
  end

  // selector register, field x at 2x+1:2x
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_source_select_r <= `P2C_RST_SEL;
    end else if (wr_acc && paddr == `P2C_ADDR_SEL) begin
      irq_source_select_r <= (irq_source_select_r & ~wmask) |
                             (wdata16 & wmask);
    end
  end

  // edge select, two bits per fast input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_edge_r <= `P2C_RST_EDGE;
    end else if (wr_acc && paddr == `P2C_ADDR_EDGE) begin
      irq_edge_r <= (irq_edge_r & ~wmask) | (wdata16 & wmask);
    end
  end

  // output latch next value, per line
  always_comb begin
    port_output_latch_nxt = port_output_latch_r;
    for (int i = 0; i < LINES; i++) begin
      if (cmp_req.trig[i]) begin
        if (cmp_req.toggle[i]) begin
          port_output_latch_nxt[i] = ~port_output_latch_r[i];
        end else begin
          port_output_latch_nxt[i] = cmp_req.set_one[i];
        end
      end
    end
    // cpu write overrides lanes it touches
    if (wr_acc && paddr == `P2C_ADDR_LATCH) begin
      port_output_latch_nxt = (port_output_latch_nxt & ~wmask) |
                              (wdata16 & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch_r <= `P2C_RST_LATCH;
    end else begin
      port_output_latch_r <= port_output_latch_nxt;
    end
  end

  // input latch, one per line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_latch_r <= 16'h0000;
    end else begin
      pin_latch_r <= pin_in;
    end
  end

  // pin drivers; open drain only pulls low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 16'h0000;
      pin_oe_n <= 16'hFFFF;
    end else begin
      for (int i = 0; i < LINES; i++) begin
        if (open_drain_control_r[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= ~(line_direction_r[i] & ~port_output_latch_r[i]);
        end else begin
          pin_out[i] <= port_output_latch_r[i];
          pin_oe_n[i] <= ~line_direction_r[i];
        end
      end
    end
  end

  // slow sample enable, once per eight clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign samp_en = (div_r == `P2C_DIV_LAST);

  // output lines reflect the latch, so writes capture
  assign cap_view = (line_direction_r & port_output_latch_r) |
                    (~line_direction_r & pin_latch_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_data <= 16'h0000;
      capture_sample <= 1'b0;
    end else begin
      capture_sample <= samp_en;
      if (samp_en) begin
        capture_data <= cap_view;
      end
    end
  end

  assign alt_src = {4'h0, clock_alarm_request, clock_seconds_request,
                    alt_rx1, alt_rx0};

  always_comb begin
    for (int x = 0; x < FAST; x++) begin
      case (p2c_pkg::p2c_src_t'(irq_source_select_r[2*x +: 2]))
        p2c_pkg::P2C_SRC_PIN: fast_src[x] = pin_latch_r[`P2C_FAST_LSB + x];
        p2c_pkg::P2C_SRC_ALT: fast_src[x] = alt_src[x];
        p2c_pkg::P2C_SRC_OR:
          fast_src[x] = pin_latch_r[`P2C_FAST_LSB + x] | alt_src[x];
        p2c_pkg::P2C_SRC_AND:
          fast_src[x] = pin_latch_r[`P2C_FAST_LSB + x] & alt_src[x];
        default: fast_src[x] = 1'b0;
      endcase
    end
  end

  // fast inputs sampled and edge-checked each clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_prev_r <= '0;
      fast_irq <= '0;
    end else begin
      fast_prev_r <= fast_src;
      for (int x = 0; x < FAST; x++) begin
        case (p2c_pkg::p2c_edge_t'(irq_edge_r[2*x +: 2]))
          p2c_pkg::P2C_EDGE_RISE: fast_irq[x] <= fast_src[x] & ~fast_prev_r[x];
          p2c_pkg::P2C_EDGE_FALL: fast_irq[x] <= ~fast_src[x] & fast_prev_r[x];
          p2c_pkg::P2C_EDGE_BOTH: fast_irq[x] <= fast_src[x] ^ fast_prev_r[x];
          default: fast_irq[x] <= 1'b0;
        endcase
      end
    end
  end

  // timer count input of the second unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_unit_timer_count_in <= 1'b0;
    end else begin
      second_unit_timer_count_in <= pin_latch_r[`P2C_T7_LINE];
    end
  end

endmodule : p2c_port
`default_nettype wire

/* verilog/p2c_regs.svh */
// register indices, byte addresses, field positions and reset values
// assumes a 32-bit APB slave; byte address is four times the index
`ifndef P2C_REGS_SVH
`define P2C_REGS_SVH

`define P2C_AW 18
`define P2C_IDX_LATCH 16'hFFC0
`define P2C_IDX_DIR 16'hFFC2
`define P2C_IDX_ODC 16'hF1C2
`define P2C_IDX_SEL 16'hF1DA
`define P2C_IDX_EDGE 16'hF1DC
`define P2C_ADDR_LATCH ({`P2C_IDX_LATCH, 2'b00})
`define P2C_ADDR_DIR ({`P2C_IDX_DIR, 2'b00})
`define P2C_ADDR_ODC ({`P2C_IDX_ODC, 2'b00})
`define P2C_ADDR_SEL ({`P2C_IDX_SEL, 2'b00})
`define P2C_ADDR_EDGE ({`P2C_IDX_EDGE, 2'b00})
`define P2C_RST_LATCH 16'h0000
`define P2C_RST_DIR 16'h0000
`define P2C_RST_ODC 16'h0000
`define P2C_RST_SEL 16'h0000
`define P2C_RST_EDGE 16'h0000
`define P2C_FAST_LSB 8
`define P2C_T7_LINE 15
`define P2C_SLOW_DIV 8
`define P2C_DIV_LAST 3'h7

`endif

/* verilog/p2c_pkg.sv */
// types shared by the port block
// no assumptions beyond a single clock domain
`default_nettype none
package p2c_pkg;

  // per-line requests from the capture/compare unit
  typedef struct packed {
    logic [15:0] trig;
    logic [15:0] toggle;
    logic [15:0] set_one;
  } p2c_cmp_t;

  typedef enum logic [1:0] {
    P2C_SRC_PIN = 2'b00,
    P2C_SRC_ALT = 2'b01,
    P2C_SRC_OR = 2'b10,
    P2C_SRC_AND = 2'b11
  } p2c_src_t;

  typedef enum logic [1:0] {
    P2C_EDGE_NONE = 2'b00,
    P2C_EDGE_RISE = 2'b01,
    P2C_EDGE_FALL = 2'b10,
    P2C_EDGE_BOTH = 2'b11
  } p2c_edge_t;

endpackage : p2c_pkg
`default_nettype wire

/* tb/p2c_port_monitor.sv */
// assertions on the port block's ports
// assumes a bind onto p2c_port, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module p2c_port_monitor #(
  parameter int LINES = 16,
  parameter int FAST = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LINES-1:0] pin_in,
  input wire logic [LINES-1:0] pin_out,
  input wire logic [LINES-1:0] pin_oe_n,
  input wire logic [LINES-1:0] capture_data,
  input wire logic capture_sample,
  input wire logic [FAST-1:0] fast_irq,
  input wire logic second_unit_timer_count_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_rdata;
    !$past(psel && !penable && !pwrite) |-> $stable(prdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_oe_rst;
    $rose(presetn) |-> pin_oe_n == '1 && pin_out == '0;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pins driven");
  property p_cap_per;
    capture_sample |=> !capture_sample [*7] ##1 capture_sample;
  endproperty
  a_cap_per: assert property (p_cap_per) else $error("sample gap");
  property p_cap_hold;
    !capture_sample |-> $stable(capture_data);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("cap moved");
  property p_t7;
    1 ##2 1 |-> second_unit_timer_count_in == $past(pin_in[15], 2);
  endproperty
  a_t7: assert property (p_t7) else $error("count input wrong");
  // upper irqs have no alternate, so a pulse needs a pin edge
  property p_fast_hi;
    fast_irq[7:4] != 0 |->
      (fast_irq[7:4] & ~($past(pin_in[15:12], 2) ^
      $past(pin_in[15:12], 3))) == 4'h0;
  endproperty
  a_fast_hi: assert property (p_fast_hi) else $error("irq no edge");
  c_cap: cover property (capture_sample);
  c_irq: cover property (fast_irq != 0);
  c_err: cover property (pslverr);
endmodule : p2c_port_monitor
bind p2c_port p2c_port_monitor #(.LINES(LINES), .FAST(FAST)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .capture_data(capture_data), .capture_sample(capture_sample),
  .fast_irq(fast_irq),
  .second_unit_timer_count_in(second_unit_timer_count_in));
`default_nettype wire

/* tb/p2c_pin_model.sv */
// outside circuitry on the sixteen pins
// assumes pin levels are sampled by p2c_port each pclk
`timescale 1ns/1ps
`default_nettype none
module p2c_pin_model (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_val,
  output logic [15:0] pin_in
);
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
endmodule : p2c_pin_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the port block
// assumes p2c_port, the pin model and the bound monitor
`include "p2c_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sample;
  logic [15:0] pin_in, pin_out, oe_n, cap, ext = '0, lat;
  logic [7:0] irq;
  logic [3:0] alt = '0, a1;
  p2c_pkg::p2c_cmp_t cmp = '0;
  logic [32:0] rq[$];
  logic [7:0] iq[$];
  int n_mismatch = 0, check_count = 0;
  always #5 pclk = ~pclk;
  p2c_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n), .cmp_req(cmp),
    .capture_data(cap), .capture_sample(sample), .alt_rx0(alt[0]),
    .alt_rx1(alt[1]), .clock_seconds_request(alt[2]),
    .clock_alarm_request(alt[3]), .fast_irq(irq),
    .second_unit_timer_count_in());
  p2c_pin_model u_pins (.pin_out(pin_out), .pin_oe_n(oe_n),
    .ext_val(ext), .pin_in(pin_in));
  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a,
    input logic [31:0] d);
    // previous access still ending: let its release edge pass first
    if (penable === 1'b1) @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    apb(1, a, {16'h0000, d});
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(0, a, '0);
  endtask : rd
  task automatic step(input logic [15:0] v, input logic [3:0] a,
    input logic [7:0] x);
    if (x != 0) iq.push_back(x);
    ext <= v;
    alt <= a;
    repeat (4) @(posedge pclk);
  endtask : step
  task automatic capwait();
    repeat (2) do @(posedge pclk); while (sample !== 1'b1);
  endtask : capwait
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, rq.pop_front());
    if (irq != 0) chk(irq, iq.size() ? iq.pop_front() : 8'h00);
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    lat = $urandom(32'h6F8D);
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`P2C_ADDR_DIR, 33'h0);
    rd(`P2C_ADDR_ODC, 33'h0);
    rd(18'h00004, 33'h100000000);
    lat = $urandom;
    wr(`P2C_ADDR_SEL, lat);
    rd(`P2C_ADDR_SEL, {17'h0, lat});
    ext <= 16'hFFFF;
    wr(`P2C_ADDR_DIR, 16'hFFFF);
    lat = $urandom;
    wr(`P2C_ADDR_LATCH, lat);
    repeat (2) @(posedge pclk);
    chk(pin_in, lat);
    wr(`P2C_ADDR_ODC, 16'hFFFF);
    repeat (2) @(posedge pclk);
    chk({oe_n, pin_out, pin_in}, {lat, 16'h0, lat});
    wr(`P2C_ADDR_ODC, 16'h0000);
    cmp <= {16'h0001, 16'h0001, 16'h0000};
    @(posedge pclk);
    cmp <= {16'h0006, 16'h0000, 16'h0002};
    @(posedge pclk);
    cmp <= {16'h0000, 16'hFFFF, 16'hFFFF};
    @(posedge pclk);
    cmp <= '0;
    rd(`P2C_ADDR_LATCH, {17'h0, (lat ^ 16'h1 | 16'h2) & 16'hFFFB});
    cmp <= {16'hFFFF, 16'hFFFF, 16'h0000};
    wr(`P2C_ADDR_LATCH, 16'h5A3C);
    cmp <= '0;
    rd(`P2C_ADDR_LATCH, 33'h5A3C);
    capwait();
    chk(cap, 16'h5A3C);
    wr(`P2C_ADDR_DIR, 16'h0000);
    ext <= $urandom;
    capwait();
    chk(cap, ext);
    step(0, 0, 0);
    wr(`P2C_ADDR_SEL, 16'h0000);
    for (int e = 0; e < 4; e++) begin
      wr(`P2C_ADDR_EDGE, {8{e[1:0]}});
      step(16'h0100, 0, e[0] ? 8'h01 : 8'h00);
      step(16'h0000, 0, e[1] ? 8'h01 : 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(`P2C_ADDR_SEL, {8{c[1:0]}});
      for (int x = 0; x < 8; x++) begin
        a1 = (x < 4) ? 4'h1 << x : 4'h0;
        step(0, a1, (x < 4 && (c == 1 || c == 2)) ? 8'h1 << x : 0);
        step(16'h0100 << x, a1, (c == 0 || c == 3 && x < 4 ||
          c == 2 && x > 3) ? 8'h1 << x : 0);
        step(0, 0, (c == 0 || c == 2 || x < 4 && (c == 1 || c == 3)) ?
          8'h1 << x : 0);
      end
    end
    chk(rq.size() + iq.size(), 0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
